//--- core/ivc_cfg.svh
// constants for the interrupt vector controller: offsets, counts, timing
// assumes one 100 MHz system clock and program-memory word addresses
`ifndef IVC_CFG_SVH
`define IVC_CFG_SVH
`define IVC_ADDR_W 24
`define IVC_RESET_ADDR 24'h00_0000
`define IVC_TRAP_BASE 24'h00_0004
`define IVC_IRQ_BASE 24'h00_0014
`define IVC_IRQ_LAST 24'h00_00FE
`define IVC_ALT_CODE_OFS 24'h00_0100
`define IVC_NUM_TRAPS 8
`define IVC_NUM_TRAPS_IMPL 6
`define IVC_NUM_IRQ 118
`define IVC_PRIO_W 3
`define IVC_OST_BITS 10
`define IVC_OST_PERIODS 1024
`define IVC_TRAP_OSC_FAIL 3'h0
`define IVC_ALT_SEL_BIT 8
`define IVC_ENTRY_LAT_NS 30
`define IVC_RETURN_LAT_NS 20
`define IVC_CLK_PERIOD_NS 10
`define IVC_ENTRY_CYC ((`IVC_ENTRY_LAT_NS + `IVC_CLK_PERIOD_NS - 1) / `IVC_CLK_PERIOD_NS)
`define IVC_RETURN_CYC ((`IVC_RETURN_LAT_NS + `IVC_CLK_PERIOD_NS - 1) / `IVC_CLK_PERIOD_NS)
`endif

//--- core/ivc_pkg.sv
// types for the interrupt vector controller
// assumes ivc_cfg.svh is on the include path
package ivc_pkg;
  typedef enum logic [3:0] {
    IVC_ST_HOLD = 4'b0001,
    IVC_ST_RUN = 4'b0010,
    IVC_ST_ENTRY = 4'b0100,
    IVC_ST_SVC = 4'b1000
  } ivc_state_t;
endpackage

//--- core/ivc_sync2.sv
// two flip-flop synchroniser for one level from outside the clock domain
// assumes the input is a quasi-static level
`timescale 1ns/1ps
module ivc_sync2 (
  // clock
  input wire logic i_clk_sys,
  // level
  input wire logic i_async,
  output logic o_sync
);
  typedef struct packed {
    logic meta_r;
    logic sync_r;
  } ivc_sync_t;
  ivc_sync_t st_r;
  ivc_sync_t st_nxt;

  always_comb begin
    st_nxt.meta_r = i_async;
    st_nxt.sync_r = st_r.meta_r;
  end

  // no reset: pin status must already be settled when reset is released,
  // so that the clock monitor's first look sees the real level
  always_ff @(posedge i_clk_sys) begin
    st_r <= st_nxt;
  end

  assign o_sync = st_r.sync_r;
endmodule

//--- core/ivc_ost.sv
// oscillator start-up counter: counts crystal periods before release
// assumes i_osc_tick is a synchronised one-cycle pulse per oscillator period
`timescale 1ns/1ps
`include "ivc_cfg.svh"
module ivc_ost #(
  parameter int unsigned CNT_W = `IVC_OST_BITS
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // control
  input wire logic i_restart,
  input wire logic i_osc_tick,
  // status
  output logic o_expired
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt_r;
    logic done_r;
  } ivc_ost_t;
  ivc_ost_t st_r;
  ivc_ost_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_restart) begin
      st_nxt = '0;
    end else if (i_osc_tick && !st_r.done_r) begin
      st_nxt.cnt_r = st_r.cnt_r + 1'b1;
      if (&st_r.cnt_r) begin
        st_nxt.done_r = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_expired = st_r.done_r;
endmodule

//--- core/ivc_top.sv
// interrupt vector controller: clock release gate, clock-fail fallback,
// trap and interrupt ranking, vector address generation, fixed latencies
// assumes the cpu pulses i_cpu_ack to accept and i_cpu_ret on return
`timescale 1ns/1ps
`include "ivc_cfg.svh"
module ivc_top
  import ivc_pkg::*;
#(
  parameter int unsigned NUM_IRQ = `IVC_NUM_IRQ,
  parameter int unsigned NUM_TRAPS = `IVC_NUM_TRAPS,
  parameter int unsigned ADDR_W = `IVC_ADDR_W,
  parameter bit BOOT_SEG_IMPL = 1'b1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // clock source status (pins, asynchronous)
  input wire logic i_osc_running,
  input wire logic i_osc_tick_raw,
  input wire logic i_pll_locked,
  input wire logic i_xtal_sel,
  input wire logic i_pll_sel,
  input wire logic i_clock_fail_monitor_en,
  // interrupt sources, same domain
  input wire logic [NUM_IRQ-1:0] i_irq,
  input wire logic [NUM_IRQ-1:0] i_irq_en,
  input wire logic [NUM_IRQ*`IVC_PRIO_W-1:0] i_irq_prio,
  input wire logic [NUM_TRAPS-1:0] i_trap,
  input wire logic [`IVC_PRIO_W-1:0] i_cpu_prio,
  // second_interrupt_control alternate select and boot base
  input wire logic i_alt_vector_select,
  input wire logic [ADDR_W-1:0] i_boot_alt_base,
  // cpu handshake
  input wire logic i_cpu_ack,
  input wire logic i_cpu_ret,
  // outputs to cpu and clock switch
  output logic o_cpu_irq,
  output logic o_exec_en,
  output logic [ADDR_W-1:0] o_pc_start,
  output logic [ADDR_W-1:0] o_vec_addr,
  output logic o_vec_valid,
  output logic o_ret_done,
  output logic o_use_fast_rc_oscillator,
  output logic o_osc_fail_trap
);
  localparam int unsigned IDX_W = $clog2(NUM_IRQ + NUM_TRAPS);
  localparam int unsigned ENT_CYC = `IVC_ENTRY_CYC;
  localparam int unsigned RET_CYC = `IVC_RETURN_CYC;
  localparam logic [3:0] ENT_LAST = 4'(ENT_CYC - 1);
  localparam logic [3:0] RET_LAST = 4'(RET_CYC - 1);

  // ==================================================
  // synchronisers and start-up counter
  // ==================================================
  logic osc_run_s;
  logic osc_tick_s;
  logic pll_lock_s;
  logic xtal_s;
  logic pll_s;
  logic mon_en_s;
  logic tick_d_r;
  logic ost_done;

  // synchronisers keep sampling through reset so status is valid at release
  ivc_sync2 u_sync_run (.i_clk_sys(i_clk_sys), .i_async(i_osc_running), .o_sync(osc_run_s));
  ivc_sync2 u_sync_tick (.i_clk_sys(i_clk_sys), .i_async(i_osc_tick_raw), .o_sync(osc_tick_s));
  ivc_sync2 u_sync_lock (.i_clk_sys(i_clk_sys), .i_async(i_pll_locked), .o_sync(pll_lock_s));
  ivc_sync2 u_sync_xtal (.i_clk_sys(i_clk_sys), .i_async(i_xtal_sel), .o_sync(xtal_s));
  ivc_sync2 u_sync_pll (.i_clk_sys(i_clk_sys), .i_async(i_pll_sel), .o_sync(pll_s));
  ivc_sync2 u_sync_mon (.i_clk_sys(i_clk_sys),
    .i_async(i_clock_fail_monitor_en), .o_sync(mon_en_s));

  // independent start-up count
  // the counter is held clear by reset and restarts whenever the oscillator stops running
  ivc_ost u_ost (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_restart(!osc_run_s),
    .i_osc_tick(osc_tick_s && !tick_d_r),
    .o_expired(ost_done)
  );

  // ==================================================
  // priority ranking
  // ==================================================
  logic cand_trap;
  logic cand_irq;
  logic [IDX_W-1:0] cand_idx;
  logic [`IVC_PRIO_W-1:0] cand_prio;
  logic clk_valid;

  // valid clock is running and released
  assign clk_valid = osc_run_s && (!xtal_s || ost_done) && (!pll_s || pll_lock_s);

  always_comb begin
    cand_trap = 1'b0;
    cand_irq = 1'b0;
    cand_idx = '0;
    cand_prio = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (i_irq[i] && i_irq_en[i] && i_irq_prio[i*`IVC_PRIO_W +: `IVC_PRIO_W] != '0 &&
          i_irq_prio[i*`IVC_PRIO_W +: `IVC_PRIO_W] >= cand_prio) begin
        cand_irq = 1'b1;
        cand_idx = IDX_W'(i);
        cand_prio = i_irq_prio[i*`IVC_PRIO_W +: `IVC_PRIO_W];
      end
    end
    // level 0 disables, seven usable levels above cpu level
    if (cand_irq && cand_prio <= i_cpu_prio) begin
      cand_irq = 1'b0;
    end
    // traps 0-4 and 6 are non-maskable and outrank all sources; traps 5 and 7 are ignored
    for (int t = NUM_TRAPS - 1; t >= 0; t--) begin
      if (i_trap[t] && t != 5 && t != 7) begin
        cand_trap = 1'b1;
        cand_idx = IDX_W'(t);
      end
    end
  end

  // ==================================================
  // controller state
  // ==================================================
  typedef struct packed {
    ivc_state_t state_r;
    logic [3:0] lat_r;
    logic mon_armed_r;
    logic fast_rc_r;
    logic fail_trap_r;
    logic exec_r;
    logic irq_r;
    logic trap_sel_r;
    logic [IDX_W-1:0] idx_r;
    logic [ADDR_W-1:0] vec_r;
    logic vec_valid_r;
    logic ret_done_r;
    logic in_ret_r;
  } ivc_top_t;
  ivc_top_t st_r;
  ivc_top_t st_nxt;
  logic [ADDR_W-1:0] table_base;
  logic alt_ok;

  // alternate table only with a boot segment
  assign alt_ok = BOOT_SEG_IMPL && i_alt_vector_select;
  assign table_base = alt_ok ? i_boot_alt_base : '0;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ret_done_r = 1'b0;
    // monitor armed at first cycle after reset release
    if (!st_r.mon_armed_r) begin
      st_nxt.mon_armed_r = 1'b1;
      // no clock: fall back to rc and trap
      if (mon_en_s && !clk_valid) begin
        st_nxt.fast_rc_r = 1'b1;
        st_nxt.fail_trap_r = 1'b1;
      end
    end else if (st_r.fail_trap_r && st_r.state_r == IVC_ST_ENTRY && st_r.trap_sel_r &&
                 st_r.idx_r == IDX_W'(`IVC_TRAP_OSC_FAIL)) begin
      st_nxt.fail_trap_r = 1'b0;
    end
    // one request line to the cpu
    st_nxt.irq_r = (cand_trap || cand_irq || st_r.fail_trap_r) && st_r.state_r == IVC_ST_RUN;
    case (st_r.state_r)
      IVC_ST_HOLD: begin
        if (st_r.mon_armed_r && (clk_valid || st_r.fast_rc_r)) begin
          st_nxt.exec_r = 1'b1;
          st_nxt.state_r = IVC_ST_RUN;
        end
      end
      IVC_ST_RUN: begin
        if (i_cpu_ack && st_r.irq_r) begin
          st_nxt.trap_sel_r = cand_trap || st_r.fail_trap_r;
          st_nxt.idx_r = st_r.fail_trap_r ? IDX_W'(`IVC_TRAP_OSC_FAIL) : cand_idx;
          st_nxt.lat_r = '0;
          st_nxt.vec_valid_r = 1'b0;
          st_nxt.irq_r = 1'b0;
          st_nxt.state_r = IVC_ST_ENTRY;
        end
      end
      IVC_ST_ENTRY: begin
        st_nxt.lat_r = st_r.lat_r + 4'h1;
        if (st_r.lat_r == ENT_LAST) begin
          // trap slot at base plus 4 plus 2n
          // vector n at base plus 14h plus 2n
          st_nxt.vec_r = table_base + (st_r.trap_sel_r ? `IVC_TRAP_BASE : `IVC_IRQ_BASE) +
                         ADDR_W'({st_r.idx_r, 1'b0});
          st_nxt.vec_valid_r = 1'b1;
          st_nxt.lat_r = '0;
          st_nxt.state_r = IVC_ST_SVC;
        end
      end
      IVC_ST_SVC: begin
        if (i_cpu_ret && !st_r.in_ret_r) begin
          st_nxt.in_ret_r = 1'b1;
          st_nxt.vec_valid_r = 1'b0;
          st_nxt.lat_r = '0;
        end else if (st_r.in_ret_r) begin
          st_nxt.lat_r = st_r.lat_r + 4'h1;
          if (st_r.lat_r == RET_LAST) begin
            st_nxt.in_ret_r = 1'b0;
            st_nxt.ret_done_r = 1'b1;
            st_nxt.state_r = IVC_ST_RUN;
          end
        end
      end
      default: begin
        st_nxt.state_r = IVC_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_r <= '{state_r: IVC_ST_HOLD, default: '0};
      tick_d_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tick_d_r <= osc_tick_s;
    end
  end

  assign o_pc_start = `IVC_RESET_ADDR;
  assign o_cpu_irq = st_r.irq_r;
  assign o_exec_en = st_r.exec_r;
  assign o_vec_addr = st_r.vec_r;
  assign o_vec_valid = st_r.vec_valid_r;
  assign o_ret_done = st_r.ret_done_r;
  assign o_use_fast_rc_oscillator = st_r.fast_rc_r;
  assign o_osc_fail_trap = st_r.fail_trap_r;

  // ==================================================
  // assertions
  // ==================================================
  exec_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_exec_en) |-> $past(clk_valid) || $past(st_r.fast_rc_r))
    else $error("execution enabled without a valid clock");
  entry_lat_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_r.state_r == IVC_ST_RUN && i_cpu_ack && o_cpu_irq) |-> ##4 o_vec_valid)
    else $error("entry latency not fixed");
  ret_lat_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_r.state_r == IVC_ST_SVC && i_cpu_ret && !st_r.in_ret_r) |-> ##3 o_ret_done)
    else $error("return latency not fixed");
  trap_addr_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_vec_valid) && st_r.trap_sel_r && !alt_ok |-> o_vec_addr <= 24'h00_0012)
    else $error("trap vector outside slots");
  irq_addr_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_vec_valid) && !st_r.trap_sel_r && !alt_ok |-> o_vec_addr >= 24'h00_0014 && o_vec_addr <= 24'h00_00FE)
    else $error("interrupt vector outside table");
  vec_even_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_vec_valid) |-> o_vec_addr[0] == table_base[0])
    else $error("vector address misaligned");
  mon_fail_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !st_r.mon_armed_r && mon_en_s && !clk_valid |=> o_use_fast_rc_oscillator && o_osc_fail_trap)
    else $error("no fallback to rc oscillator");
  req_merge_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_r.state_r == IVC_ST_RUN && cand_trap |=> o_cpu_irq || $past(i_cpu_ack))
    else $error("pending trap not requested");
  no_req_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_cpu_irq |-> $past(cand_trap || cand_irq || st_r.fail_trap_r))
    else $error("request with nothing pending");
  pc_zero_a: assert property (@(posedge i_clk_sys) o_pc_start == '0)
    else $error("start address not zero");
  ret_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_ret_done |=> !o_ret_done)
    else $error("return done longer than one cycle");
  irq_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_r.state_r == IVC_ST_RUN && i_cpu_ack && o_cpu_irq |=> !o_cpu_irq)
    else $error("request kept after acceptance");
  no_nest_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_r.state_r != IVC_ST_RUN |=> !o_cpu_irq)
    else $error("request raised outside run state");
  hold_exec_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_r.state_r == IVC_ST_HOLD |-> !o_exec_en)
    else $error("execution enabled while held");
  exec_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_exec_en |=> o_exec_en)
    else $error("execution enable dropped without reset");
  // the cpu fetches from the vector for as long as it serves the handler
  vec_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_vec_valid && !i_cpu_ret |=> o_vec_valid && $stable(o_vec_addr))
    else $error("vector changed during service");
  alt_base_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_vec_valid) && alt_ok |-> o_vec_addr >= i_boot_alt_base)
    else $error("alternate vector below its base");
  trap_first_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_r.state_r == IVC_ST_RUN && i_cpu_ack && o_cpu_irq && cand_trap |=> st_r.trap_sel_r)
    else $error("interrupt taken over pending trap");
  osc_first_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_r.state_r == IVC_ST_RUN && i_cpu_ack && o_cpu_irq && st_r.fail_trap_r |=>
    st_r.trap_sel_r && st_r.idx_r == '0)
    else $error("oscillator fail trap not served first");
  ost_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_exec_en) && !st_r.fast_rc_r |-> $past(ost_done || !xtal_s))
    else $error("crystal released before start-up count");
  rc_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_use_fast_rc_oscillator |=> o_use_fast_rc_oscillator)
    else $error("rc fallback dropped without reset");
  mon_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_r.mon_armed_r |=> st_r.mon_armed_r)
    else $error("clock monitor disarmed");
  entry_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $rose(o_vec_valid) && !st_r.trap_sel_r);
  trap_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $rose(o_vec_valid) && st_r.trap_sel_r);
  fail_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $rose(o_use_fast_rc_oscillator));
  alt_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $rose(o_vec_valid) && alt_ok);
  ret_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) o_ret_done);
endmodule

//--- bench/ivc_cpu_model.sv
// cpu model: takes the merged request, acks, waits for the vector,
// serves a while, returns, and times both entry and return
// assumes the controller's registered handshake on i_clk_sys
`timescale 1ns/1ps
module ivc_cpu_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // controller side
  input wire logic i_run,
  input wire logic i_irq,
  input wire logic i_vec_valid,
  input wire logic [23:0] i_vec_addr,
  input wire logic i_ret_done,
  input wire logic [3:0] i_ack_dly,
  output logic o_ack,
  output logic o_ret,
  // observations
  output logic [23:0] o_addr,
  output logic [7:0] o_cnt,
  output logic [3:0] o_lat,
  output logic [3:0] o_rlat
);
  // ==========
  // handshake
  logic [2:0] st_r;
  logic [3:0] n_r;
  always @(posedge i_clk_sys) begin
    o_ack <= 1'b0;
    o_ret <= 1'b0;
    if (i_sys_rst) begin
      st_r <= 3'h0;
      o_cnt <= 8'h00;
    end else begin
      case (st_r)
        3'h0: if (i_run && i_irq) begin
          n_r <= i_ack_dly;
          st_r <= 3'h1;
        end
        3'h1: if (n_r == 4'h0) begin
          o_ack <= 1'b1;
          o_lat <= 4'h0;
          st_r <= 3'h2;
        end else n_r <= n_r - 4'h1;
        3'h2: if (i_vec_valid) begin
          o_addr <= i_vec_addr;
          o_cnt <= o_cnt + 8'h01;
          n_r <= 4'h6;
          st_r <= 3'h3;
        end else o_lat <= o_lat + 4'h1;
        3'h3: if (n_r == 4'h0) begin
          o_ret <= 1'b1;
          o_rlat <= 4'h0;
          st_r <= 3'h4;
        end else n_r <= n_r - 4'h1;
        default: if (i_ret_done) st_r <= 3'h0;
        else o_rlat <= o_rlat + 4'h1;
      endcase
    end
  end
endmodule

//--- bench/tb_interrupt_vector_controller.sv
// bench for the interrupt vector controller with a cpu model
// assumes ivc_cfg.svh on the include path; all inputs driven at posedge
`timescale 1ns/1ps
module tb_interrupt_vector_controller;
  // ==========
  // stimulus
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic osc_run = 1'b0, tick_on = 1'b0, locked = 1'b0;
  logic xtal = 1'b0, pll = 1'b0, mon = 1'b0, alt = 1'b0;
  logic [2:0] tdiv = 3'h0;
  logic [117:0] irq = '0, en = '0;
  logic [353:0] prio = '0;
  logic [7:0] trap = 8'h00;
  logic [2:0] cpu_prio = 3'h0;
  logic [23:0] base = 24'h00_0000;
  logic [3:0] dly = 4'h0;
  logic ack, ret, cpu_irq, exec_en, vvalid, rdone, rc, ftrap;
  logic [23:0] pc0, vaddr, maddr;
  logic [7:0] mcnt;
  logic [3:0] lat, rlat;
  int failures = 0;
  int checks = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  // oscillator square wave, eight clocks a period
  always @(posedge i_clk_sys) tdiv <= tick_on ? tdiv + 3'h1 : 3'h0;
  ivc_top ivc_top_inst (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_osc_running(osc_run), .i_osc_tick_raw(tdiv[2]), .i_pll_locked(locked),
    .i_xtal_sel(xtal), .i_pll_sel(pll), .i_clock_fail_monitor_en(mon),
    .i_irq(irq), .i_irq_en(en), .i_irq_prio(prio), .i_trap(trap),
    .i_cpu_prio(cpu_prio), .i_alt_vector_select(alt), .i_boot_alt_base(base),
    .i_cpu_ack(ack), .i_cpu_ret(ret), .o_cpu_irq(cpu_irq), .o_exec_en(exec_en),
    .o_pc_start(pc0), .o_vec_addr(vaddr), .o_vec_valid(vvalid), .o_ret_done(rdone),
    .o_use_fast_rc_oscillator(rc), .o_osc_fail_trap(ftrap));
  ivc_cpu_model ivc_cpu_model_inst (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_run(exec_en), .i_irq(cpu_irq), .i_vec_valid(vvalid), .i_vec_addr(vaddr),
    .i_ret_done(rdone), .i_ack_dly(dly), .o_ack(ack), .o_ret(ret), .o_addr(maddr),
    .o_cnt(mcnt), .o_lat(lat), .o_rlat(rlat));
  // ==========
  // helpers
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({23'h00_0000, g}, {23'h00_0000, e});
  endtask
  task automatic step();
    @(posedge i_clk_sys);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic req(input int i, input logic [2:0] p);
    irq[i] <= 1'b1;
    en[i] <= 1'b1;
    prio[3*i +: 3] <= p;
  endtask
  task automatic serve(input logic [23:0] e);
    logic [7:0] c0;
    c0 = mcnt;
    for (int k = 0; k < 100 && mcnt === c0; k++) cyc(1);
    chk(maddr, e);
    chk({20'h0_0000, lat}, 24'h00_0004);
  endtask
  task automatic do_reset();
    step();
    i_sys_rst <= 1'b1;
    cyc(4);
    chk({18'h0_0000, cpu_irq, exec_en, vvalid, rdone, rc, ftrap}, 24'h00_0000);
    chk(pc0, 24'h00_0000);
    cyc(3);
    step();
    i_sys_rst <= 1'b0;
  endtask
  // ==========
  // scenarios
  task automatic boot_xtal();
    step();
    xtal <= 1'b1;
    pll <= 1'b1;
    do_reset();
    cyc(20);
    chk1(exec_en, 1'b0);
    step();
    osc_run <= 1'b1;
    tick_on <= 1'b1;
    cyc(8000);
    chk1(exec_en, 1'b0);
    cyc(400);
    chk1(exec_en, 1'b0);
    step();
    locked <= 1'b1;
    cyc(10);
    chk1(exec_en, 1'b1);
  endtask
  task automatic fail_rc();
    step();
    osc_run <= 1'b0;
    tick_on <= 1'b0;
    locked <= 1'b0;
    mon <= 1'b1;
    dly <= 4'hF;
    do_reset();
    cyc(4);
    chk1(rc, 1'b1);
    chk1(ftrap, 1'b1);
    chk1(exec_en, 1'b1);
    serve(24'h00_0004);
    chk1(ftrap, 1'b0);
    cyc(20);
    chk({20'h0_0000, rlat}, 24'h00_0003);
  endtask
  task automatic rank();
    step();
    dly <= 4'h5;
    req(100, 3'h6);
    req(2, 3'h3);
    req(5, 3'h3);
    serve(24'h00_00DC);
    step();
    irq[100] <= 1'b0;
    serve(24'h00_0018);
    step();
    irq[2] <= 1'b0;
    serve(24'h00_001E);
    step();
    irq[5] <= 1'b0;
    cpu_prio <= 3'h6;
    req(117, 3'h6);
    req(9, 3'h0);
    irq[3] <= 1'b1;
    prio[11:9] <= 3'h7;
    cyc(30);
    chk1(cpu_irq, 1'b0);
    step();
    cpu_prio <= 3'h5;
    serve(24'h00_00FE);
    step();
    irq <= '0;
    cpu_prio <= 3'h0;
  endtask
  task automatic traps();
    step();
    dly <= 4'h0;
    trap <= 8'hE2;
    req(0, 3'h7);
    serve(24'h00_0006);
    step();
    trap[1] <= 1'b0;
    serve(24'h00_0010);
    step();
    trap[6] <= 1'b0;
    serve(24'h00_0014);
    step();
    irq[0] <= 1'b0;
    cyc(30);
    chk1(cpu_irq, 1'b0);
    chk(maddr, 24'h00_0014);
    step();
    trap <= 8'h00;
  endtask
  task automatic alt_table();
    step();
    alt <= 1'b1;
    base <= 24'h00_8000;
    trap[3] <= 1'b1;
    req(117, 3'h1);
    serve(24'h00_800A);
    step();
    trap[3] <= 1'b0;
    serve(24'h00_80FE);
    chk(maddr - base, 24'h00_00FE);
    step();
    irq[117] <= 1'b0;
    alt <= 1'b0;
    step();
    req(0, 3'h1);
    serve(24'h00_0014);
    step();
    irq[0] <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    boot_xtal();
    fail_rc();
    rank();
    traps();
    alt_table();
    summarize();
  end
  // expected run is near 10000 clocks; allow four times that
  initial begin
    #400000;
    failures++;
    summarize();
  end
endmodule
